// File: src/subset_exec_defines.vh
`ifndef SUBSET_EXEC_DEFINES_VH
`define SUBSET_EXEC_DEFINES_VH

// Widths
`define DATA_W         8
`define PC_W           10
`define CP_ADDR_W      4
`define CP_DEPTH       16
`define STACK_PTR_W    3

// Decoded operation codes on i_op
`define OP_NOP         4'h0
`define OP_OR_LIT      4'h1
`define OP_LOAD_LIT    4'h2
`define OP_RD_CP       4'h3
`define OP_WR_CP       4'h4
`define OP_LONG_CALL   4'h5
`define OP_LONG_JUMP   4'h6
`define OP_INC_SKIP    4'h7

// Reset values
`define RST_WORK       8'h00
`define RST_PC         10'h000
`define RST_SP         3'h0

// Cycle counts
`define CYC_FLUSH      1

`endif

// File: src/control_page.v
`timescale 1ns/1ps

// Sixteen-entry control-register page, written by one port, read combinationally
module control_page (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire       i_we,
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    output wire [7:0] o_rdata
);

    reg [7:0] page_ff [0:15];    // Register storage

    // Clear on reset, store on write
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_ent
            always @(posedge i_clk) begin
                if (!i_rst_n) begin
                    page_ff[g] <= 8'h00;
                end else if (i_we && (i_addr == g)) begin
                    page_ff[g] <= i_wdata;
                end
            end
        end
    endgenerate

    assign o_rdata = page_ff[i_addr];    // Selected entry

endmodule // control_page

// File: src/mcu_instruction_subset_exec.v
`timescale 1ns/1ps
`include "subset_exec_defines.vh"

module mcu_instruction_subset_exec (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire       i_valid,        // Instruction present this cycle
    input  wire [3:0] i_op,           // Decoded operation
    input  wire [9:0] i_imm,          // Literal, page index or target
    input  wire [7:0] i_inc_result,   // Increment result from the data path
    output wire       o_busy,         // Flush cycle in progress
    output reg  [9:0] o_pc,           // Program counter
    output reg  [7:0] o_working,      // Working register
    output reg        o_zero,         // Zero flag
    output reg  [2:0] o_stack_ptr,    // Return stack pointer
    output reg        o_push,         // Push strobe, one cycle
    output reg  [9:0] o_push_addr,    // Pushed return address
    output reg        o_cp_we,        // Page write strobe, one cycle
    output reg  [3:0] o_cp_addr,      // Page write index
    output reg  [7:0] o_cp_wdata,     // Page write data
    output reg        o_skipped       // Pulses when an instruction was discarded
);

    // Timing in brief: an instruction is taken at the rising edge where
    // i_valid is high and the block is not busy; its results appear in the
    // registered outputs right after that edge. A call, a long jump or a
    // skipping increment adds one flush cycle, during which whatever sits
    // on i_op is the instruction fetched behind it and is ignored.

    // Two-state sequencer
    localparam ST_RUN   = 1'b0;    // Executing fetched instructions
    localparam ST_FLUSH = 1'b1;    // Discarding fetched instruction

    // Sequencer state
    reg        state_ff;           // Current state
    reg        nxt_state;          // State for the next cycle

    // Next values of the registered outputs
    reg [9:0]  nxt_pc;             // Program counter
    reg [7:0]  nxt_working;        // Working register
    reg        nxt_zero;           // Zero flag
    reg [2:0]  nxt_sp;             // Return stack pointer
    reg        nxt_push;           // Push strobe
    reg [9:0]  nxt_push_addr;      // Return address to push
    reg        nxt_cp_we;          // Page write request
    reg        nxt_skipped;        // Discard pulse

    // Data path helpers
    reg [7:0]  or_val;             // OR result
    wire [7:0] cp_rdata;           // Page read data
    wire [9:0] pc_plus1;           // Sequential address

    // True for the two long transfers of control; both leave the program
    // counter parked on their target through the flush cycle
    function is_branch_op;
        input [3:0] op;            // Decoded operation
        begin
            is_branch_op = (op == `OP_LONG_CALL) || (op == `OP_LONG_JUMP);
        end
    endfunction

    // Address of the following instruction; wraps from the top of memory
    assign pc_plus1 = o_pc + 10'h001;
    // Busy for exactly the flush cycle
    assign o_busy   = (state_ff == ST_FLUSH);

    // Control page storage. It is written at the edge that takes the write,
    // so a read in the very next cycle already sees the new value
    control_page u_page (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (nxt_cp_we),
        .i_addr  (i_imm[3:0]),
        .i_wdata (o_working),
        .o_rdata (cp_rdata)
    );

    // Next-state and execute logic
    always @* begin
        // Hold everything by default; strobes drop back to zero
        nxt_state     = ST_RUN;
        nxt_pc        = o_pc;
        nxt_working   = o_working;
        nxt_zero      = o_zero;
        nxt_sp        = o_stack_ptr;
        nxt_push      = 1'b0;
        nxt_push_addr = o_push_addr;
        nxt_cp_we     = 1'b0;
        nxt_skipped   = 1'b0;
        // OR formed every cycle; only the OR case uses it
        or_val        = o_working | i_imm[7:0];

        case (state_ff)
            ST_FLUSH: begin
                // Fetched instruction discarded, no-op here
                nxt_skipped = 1'b1;
                // A jump's target is held instead, in the register stage
                nxt_pc      = pc_plus1;
            end
            ST_RUN: begin
                // Only a valid instruction moves the program counter
                if (i_valid) begin
                    nxt_pc = pc_plus1;
                    case (i_op)
                        // Working OR literal, zero flag from the result
                        `OP_OR_LIT: begin
                            nxt_working = or_val;
                            nxt_zero    = (or_val == 8'h00);
                        end

                        // Literal straight into working, flags untouched
                        `OP_LOAD_LIT: begin
                            nxt_working = i_imm[7:0];
                        end

                        // Page data is combinational, done in one cycle
                        `OP_RD_CP: begin
                            nxt_working = cp_rdata;
                        end

                        // Page latches working at this edge
                        `OP_WR_CP: begin
                            nxt_cp_we = 1'b1;
                        end

                        // Return address goes out with the push strobe;
                        // the pointer wraps after eight nested calls
                        `OP_LONG_CALL: begin
                            nxt_push      = 1'b1;
                            nxt_push_addr = pc_plus1;
                            nxt_sp        = o_stack_ptr + 3'h1;
                            nxt_pc        = i_imm;
                            nxt_state     = ST_FLUSH;
                        end

                        // No push and no flag change, only the counter
                        `OP_LONG_JUMP: begin
                            nxt_pc    = i_imm;
                            nxt_state = ST_FLUSH;
                        end

                        `OP_INC_SKIP: begin
                            // Zero result discards the next fetch
                            // A nonzero result runs on with no extra cycle
                            if (i_inc_result == 8'h00) begin
                                nxt_state = ST_FLUSH;
                            end
                        end

                        // No-op and codes outside this subset
                        default: begin
                            nxt_pc = pc_plus1;                   // No-op and others
                        end
                    endcase
                end
            end
            // Unused state code falls back to running
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // Flush after a jump lands on the target, no extra advance. A skip
    // flush instead steps over the discarded instruction, so it advances
    wire flush_is_jump;            // Current flush belongs to a call or jump
    reg  jump_ff;                  // Flush came from a jump
    assign flush_is_jump = jump_ff;

    // State registers; the synchronous reset clears every output, and the
    // page clears itself on the same reset
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            // Idle, counter at the reset vector, no strobes
            state_ff    <= ST_RUN;
            jump_ff     <= 1'b0;
            o_pc        <= `RST_PC;
            o_working   <= `RST_WORK;
            o_zero      <= 1'b0;
            o_stack_ptr <= `RST_SP;
            o_push      <= 1'b0;
            o_push_addr <= `RST_PC;
            o_cp_we     <= 1'b0;
            o_cp_addr   <= 4'h0;
            o_cp_wdata  <= 8'h00;
            o_skipped   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            // Remember whether the coming flush belongs to a call or jump
            jump_ff     <= (state_ff == ST_RUN) && i_valid && is_branch_op(i_op);
            // Jump target already holds the fetch address, so flush keeps it
            o_pc        <= (state_ff == ST_FLUSH && flush_is_jump) ? o_pc : nxt_pc;

            // Data path registers
            o_working   <= nxt_working;
            o_zero      <= nxt_zero;
            o_stack_ptr <= nxt_sp;

            // One-cycle strobes and the pushed return address
            o_push      <= nxt_push;
            o_push_addr <= nxt_push_addr;
            o_cp_we     <= nxt_cp_we;

            // Record of the last page write, held between writes
            o_cp_addr   <= nxt_cp_we ? i_imm[3:0] : o_cp_addr;
            o_cp_wdata  <= nxt_cp_we ? o_working : o_cp_wdata;
            o_skipped   <= nxt_skipped;
        end
    end

endmodule // mcu_instruction_subset_exec

// File: verif/subset_exec_chk_sva.sv
`timescale 1ns/1ps
// Watches the execution block's ports
module subset_exec_chk (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_valid,
    input wire logic [3:0] i_op,
    input wire logic [9:0] i_imm,
    input wire logic [7:0] i_inc_result,
    input wire logic       o_busy,
    input wire logic [9:0] o_pc,
    input wire logic [7:0] o_working,
    input wire logic       o_zero,
    input wire logic [2:0] o_stack_ptr,
    input wire logic       o_push,
    input wire logic [9:0] o_push_addr,
    input wire logic       o_cp_we,
    input wire logic [3:0] o_cp_addr,
    input wire logic [7:0] o_cp_wdata,
    input wire logic       o_skipped
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire tk = i_valid && !o_busy; // Instruction taken
    logic [7:0] shadow_ff [0:15]; // Expected page contents
    // Shadow page follows every taken write, cleared with the design
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 16; k++) shadow_ff[k] <= 8'h00;
        end else if (tk && i_op == 4'h4) begin
            shadow_ff[i_imm[3:0]] <= o_working;
        end
    end
    property p_skip; tk && i_op == 4'h7 && i_inc_result == 8'h00 |=> o_busy ##1 o_skipped;
    endproperty
    a_skip: assert property (p_skip) else $error("skip lost");
    property p_noskip; tk && i_op == 4'h7 && i_inc_result != 8'h00 |=> !o_busy && !o_skipped;
    endproperty
    a_noskip: assert property (p_noskip) else $error("skip spurious");
    property p_or; tk && i_op == 4'h1 |=> o_working == ($past(o_working) | $past(i_imm[7:0]))
        && o_zero == (o_working == 8'h00); endproperty
    a_or: assert property (p_or) else $error("or wrong");
    property p_load; tk && i_op == 4'h2 |=> o_working == $past(i_imm[7:0]) && $stable(o_zero);
    endproperty
    a_load: assert property (p_load) else $error("load wrong");
    property p_rd; tk && i_op == 4'h3 |=> $stable(o_zero) && !o_busy
        && o_working == shadow_ff[$past(i_imm[3:0])]; endproperty
    a_rd: assert property (p_rd) else $error("read wrong");
    property p_wr; tk && i_op == 4'h4 |=> o_cp_we && o_cp_wdata == $past(o_working)
        && o_cp_addr == $past(i_imm[3:0]) && $stable(o_working); endproperty
    a_wr: assert property (p_wr) else $error("write wrong");
    property p_call; tk && i_op == 4'h5 |=> o_push && o_push_addr == $past(o_pc) + 10'h001
        && o_stack_ptr == $past(o_stack_ptr) + 3'h1; endproperty
    a_call: assert property (p_call) else $error("push wrong");
    property p_callpc; tk && i_op == 4'h5 |=> o_pc == $past(i_imm) && o_busy
        && $stable(o_zero) ##1 o_skipped; endproperty
    a_callpc: assert property (p_callpc) else $error("call wrong");
    property p_jump; tk && i_op == 4'h6 |=> o_pc == $past(i_imm) && !o_push
        && $stable(o_stack_ptr) && $stable(o_zero) ##1 o_skipped; endproperty
    a_jump: assert property (p_jump) else $error("jump wrong");
endmodule // subset_exec_chk

// File: verif/mcu_instruction_subset_exec_tb.sv
`timescale 1ns/1ps
`include "subset_exec_defines.vh"
module mcu_instruction_subset_exec_tb;
    logic       i_clk = 0, i_rst_n = 0, i_valid = 0, o_busy, o_zero, o_push, o_cp_we, o_skipped;
    logic [3:0] i_op = 0, o_cp_addr;
    logic [9:0] i_imm = 0, o_pc, o_push_addr;
    logic [7:0] i_inc_result = 0, o_working, o_cp_wdata;
    logic [2:0] o_stack_ptr;
    int         n_fail = 0, num_checks = 0;
    always #10 i_clk = ~i_clk; // 50 MHz
    mcu_instruction_subset_exec DUT (.*);
    // Compares one result
    task chk(string nm, logic [9:0] e, logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // Presents one instruction; keep holds it into the flush cycle
    task op(logic [3:0] c, logic [9:0] v, logic [7:0] r = 8'h01, bit keep = 0);
        @(posedge i_clk);
        i_valid <= 1;
        i_op <= c;
        i_imm <= v;
        i_inc_result <= r;
        @(posedge i_clk);
        i_valid <= keep;
        @(negedge i_clk);
    endtask
    // Advances one cycle with no request
    task nxt;
        @(posedge i_clk);
        i_valid <= 0;
        @(negedge i_clk);
    endtask
    // Literal load, OR and zero flag
    task t_alu;
        op(`OP_LOAD_LIT, 10'h0aa);
        op(`OP_OR_LIT, 10'h050);
        chk("work", 10'h0fa, o_working);
        op(`OP_LOAD_LIT, 10'h000);
        op(`OP_OR_LIT, 10'h000);
        chk("zero", 10'h001, o_zero);
        op(`OP_LOAD_LIT, 10'h055);
        chk("work", 10'h055, o_working);
        chk("zero", 10'h001, o_zero);
    endtask
    // Top page entry written then read back
    task t_page;
        op(`OP_WR_CP, 10'h00f);
        chk("we", 10'h001, o_cp_we);
        chk("idx", 10'h00f, o_cp_addr);
        chk("wdat", 10'h055, o_cp_wdata);
        op(`OP_LOAD_LIT, 10'h0c0);
        op(`OP_RD_CP, 10'h00f);
        chk("work", 10'h055, o_working);
        chk("zero", 10'h001, o_zero);
    endtask
    // Jumps and a call whose return address wraps; call held into flush
    task t_flow;
        op(`OP_LONG_JUMP, 10'h3ff);
        chk("pc", 10'h3ff, o_pc);
        chk("busy", 10'h001, o_busy);
        op(`OP_LONG_CALL, 10'h123, 8'h01, 1);
        chk("ret", 10'h000, o_push_addr);
        chk("push", 10'h001, o_push);
        chk("pc", 10'h123, o_pc);
        nxt;
        chk("done", 10'h001, o_skipped);
        op(`OP_LONG_JUMP, 10'h000);
        chk("sp", 10'h001, o_stack_ptr);
        chk("zero", 10'h001, o_zero);
    endtask
    // Zero result skips, nonzero does not
    task t_skip;
        op(`OP_LONG_JUMP, 10'h100);
        op(`OP_INC_SKIP, 10'h000, 8'h00);
        chk("busy", 10'h001, o_busy);
        nxt;
        chk("pc", 10'h102, o_pc);
        op(`OP_INC_SKIP, 10'h000, 8'h01);
        chk("busy", 10'h000, o_busy);
        chk("pc", 10'h103, o_pc);
        op(`OP_NOP, 10'h3ff);
        chk("pc", 10'h104, o_pc);
    endtask
    // Prints counts and verdict
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1;
        t_alu;
        t_page;
        t_flow;
        t_skip;
        tally_and_finish;
    end
    initial begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
endmodule // mcu_instruction_subset_exec_tb
bind mcu_instruction_subset_exec subset_exec_chk chk (.*);
